// [verilog/irq_pkg.sv]
// constants, field layouts and carriers of the interrupt controller
package irq_pkg;

  // special-register indices on the core's data-memory port
  localparam int SFR_AW = 3;
  localparam logic [2:0] ADDR_EDGE_SEL = 3'h0;
  localparam logic [2:0] ADDR_CTRL0 = 3'h1;
  localparam logic [2:0] ADDR_CTRL1 = 3'h2;
  localparam logic [2:0] ADDR_CTRL2 = 3'h3;
  localparam logic [2:0] ADDR_MFI = 3'h4;

  localparam logic [7:0] REG_RESET = 8'h00;

  // ext_edge_select fields
  localparam int EDGE_LSB = 0;
  localparam int EDGE_MSB = 1;
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // irq_control_0 fields
  localparam int C0_GLOBAL_EN = 0;
  localparam int C0_EXT_EN = 1;
  localparam int C0_MF_EN = 2;
  localparam int C0_TB0_EN = 3;
  localparam int C0_EXT_FLAG = 4;
  localparam int C0_MF_FLAG = 5;
  localparam int C0_TB0_FLAG = 6;

  // irq_control_1 fields
  localparam int C1_TB1_EN = 0;
  localparam int C1_CONV_EN = 1;
  localparam int C1_EE_EN = 2;
  localparam int C1_SIM_EN = 3;
  localparam int C1_TB1_FLAG = 4;
  localparam int C1_CONV_FLAG = 5;
  localparam int C1_EE_FLAG = 6;
  localparam int C1_SIM_FLAG = 7;

  // irq_control_2 fields
  localparam int C2_SPORT_EN = 0;
  localparam int C2_SPORT_FLAG = 4;

  // multi_function_irq: enables in the low nibble, flags in the high one
  localparam int MFI_EN_LSB = 0;
  localparam int MFI_EN_MSB = 3;
  localparam int MFI_FLAG_LSB = 4;
  localparam int MFI_FLAG_MSB = 7;
  localparam int NUM_MF = 4;

  // primary sources, lowest index served first
  localparam int NUM_SRC = 8;
  localparam int SRC_W = 3;
  localparam int SRC_EXT = 0;
  localparam int SRC_TB0 = 1;
  localparam int SRC_MF = 2;
  localparam int SRC_CONV = 3;
  localparam int SRC_TB1 = 4;
  localparam int SRC_EE = 5;
  localparam int SRC_SIM = 6;
  localparam int SRC_SPORT = 7;

  // system clock start-up after a wake-up
  localparam int CLK_PERIOD_NS = 20;
  localparam int STARTUP_TIME_NS = 20000;
  localparam int STARTUP_CYCLES = (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP_W = 12;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_OFF = 3'b010,
    ST_WARM = 3'b100
  } pwr_state_t;

  // one-cycle event pulses from the internal peripherals
  typedef struct packed {
    logic timeBase0;
    logic timeBase1;
    logic converterDone;
    logic eepromWriteDone;
    logic serialIntfDone;
    logic timerCPeriod;
    logic timerCCmpA;
    logic timerPPeriod;
    logic timerPCmpA;
  } periph_evt_t;

  // serial port control bits held in its own control registers
  typedef struct packed {
    logic serialPortEnable;
    logic receiverEnable;
    logic rxIrqEnable;
    logic wakeEnable;
    logic addrDetectMode;
    logic nineBitWordSelect;
    logic parityEnable;
    logic txEmptyIrqEnable;
    logic txIdleIrqEnable;
  } serial_cfg_t;

  // serial port status; levels except rxWordDone
  typedef struct packed {
    logic txEmpty;
    logic txIdle;
    logic rxTrigger;
    logic rxOverrun;
    logic rxWordDone;
    logic rxBit8;
    logic rxBit7;
  } serial_stat_t;

endpackage

// [verilog/edge_sync.sv]
// two-stage pin synchroniser with rise and fall pulses
`timescale 1ns/100ps
module edge_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // pin and detected edges
  input wire logic pinAsync,
  output logic pinLevel,
  output logic rise,
  output logic fall
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_q <= RESET_LEVEL;
      sync_q <= RESET_LEVEL;
      prev_q <= RESET_LEVEL;
    end
    else
    begin
      meta_q <= pinAsync;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign pinLevel = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
endmodule // edge_sync

// [verilog/uart_irq_merge.sv]
// serial port condition merge into one active-low request pulse
`timescale 1ns/100ps
module uart_irq_merge (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // serial port state
  input wire irq_pkg::serial_cfg_t cfg,
  input wire irq_pkg::serial_stat_t stat,
  input wire logic clkRun,
  input wire logic rxFall,
  // toward the controller
  output logic irqPulseN,
  output logic wakeEvt
);
  logic [3:0] cond_q;
  logic [3:0] cond_d;
  logic [3:0] condLevel;
  logic topBit;
  logic rxAvail;
  logic addrHit;
  logic newCond;
  logic wake;
  logic irqPulseN_q;
  logic wakeEvt_q;

  assign topBit = cfg.nineBitWordSelect ? stat.rxBit8 : stat.rxBit7;
  assign rxAvail = stat.rxTrigger & cfg.rxIrqEnable
                 & (~cfg.addrDetectMode | topBit);
  assign addrHit = cfg.addrDetectMode & stat.rxWordDone & topBit & cfg.rxIrqEnable;
  assign condLevel = {stat.txEmpty & cfg.txEmptyIrqEnable,
                      stat.txIdle & cfg.txIdleIrqEnable,
                      rxAvail,
                      stat.rxOverrun & cfg.rxIrqEnable};
  // frozen while the port clock is off so a condition that rose meanwhile fires on its return
  assign cond_d = clkRun ? condLevel : cond_q;
  assign newCond = clkRun & ((|(condLevel & ~cond_q)) | addrHit);
  assign wake = ~clkRun & cfg.serialPortEnable & cfg.receiverEnable
              & cfg.rxIrqEnable & cfg.wakeEnable & rxFall;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      cond_q <= 4'h0;
      irqPulseN_q <= 1'b1;
      wakeEvt_q <= 1'b0;
    end
    else
    begin
      cond_q <= cond_d;
      irqPulseN_q <= ~newCond;
      wakeEvt_q <= wake;
    end
  end

  assign irqPulseN = irqPulseN_q;
  assign wakeEvt = wakeEvt_q;
endmodule // uart_irq_merge

// [verilog/mcu_irq_ctrl.sv]
// interrupt request, enable and serial-port interrupt controller
`timescale 1ns/100ps
module mcu_irq_ctrl #(
  parameter int STARTUP_COUNT = irq_pkg::STARTUP_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // special register port
  input wire logic [irq_pkg::SFR_AW-1:0] sfrAddr,
  input wire logic sfrWr,
  input wire logic sfrRd,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] sfrRdata,
  // pins
  input wire logic extIntPin,
  input wire logic rxPin,
  // internal peripherals
  input wire irq_pkg::periph_evt_t periphEvt,
  input wire irq_pkg::serial_cfg_t serialCfg,
  input wire irq_pkg::serial_stat_t serialStat,
  input wire logic serialClkOn,
  output logic rxDiscard,
  // processor core
  input wire logic stackFull,
  input wire logic vectorTaken,
  output logic irqReq,
  output logic [irq_pkg::SRC_W-1:0] irqSrc,
  output logic wakeCore
);
  // register file
  logic [1:0] edgeSel_q;
  logic globalEn_q;
  logic [irq_pkg::NUM_SRC-1:0] flag_q;
  logic [irq_pkg::NUM_SRC-1:0] flag_d;
  logic [irq_pkg::NUM_SRC-1:0] en_q;
  logic [irq_pkg::NUM_SRC-1:0] en_d;
  logic [irq_pkg::NUM_MF-1:0] mfFlag_q;
  logic [irq_pkg::NUM_MF-1:0] mfFlag_d;
  logic [irq_pkg::NUM_MF-1:0] mfEn_q;
  logic [7:0] sfrRdata_q;

  // request to the core
  logic irqReq_q;
  logic [irq_pkg::SRC_W-1:0] irqSrc_q;
  logic [irq_pkg::SRC_W-1:0] pick;
  logic [irq_pkg::NUM_SRC-1:0] hit;
  logic [irq_pkg::NUM_SRC-1:0] ackClr;

  // power / start-up tracking
  irq_pkg::pwr_state_t state_q;
  irq_pkg::pwr_state_t state_d;
  logic [irq_pkg::STARTUP_W-1:0] warmCnt_q;
  logic uartHeld_q;
  logic wakeCore_q;
  logic rxDiscard_q;

  // decode
  logic wrEdge;
  logic wrCtrl0;
  logic wrCtrl1;
  logic wrCtrl2;
  logic wrMfi;
  logic [irq_pkg::NUM_SRC-1:0] flagWrMask;
  logic [irq_pkg::NUM_SRC-1:0] flagWrVal;
  logic [irq_pkg::NUM_SRC-1:0] evt;
  logic [irq_pkg::NUM_MF-1:0] mfEvt;
  logic [7:0] rdMux;

  // pin edges and serial merge
  logic extRise;
  logic extFall;
  logic rxFall;
  logic extEvt;
  logic uartPulseN;
  logic uartWake;
  logic uartEvt;
  logic stRun;
  logic warmDone;

  edge_sync #(.RESET_LEVEL(1'b0)) u_extSync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pinAsync(extIntPin),
    .pinLevel(),
    .rise(extRise),
    .fall(extFall)
  );

  // serial line idles high
  edge_sync #(.RESET_LEVEL(1'b1)) u_rxSync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pinAsync(rxPin),
    .pinLevel(),
    .rise(),
    .fall(rxFall)
  );

  uart_irq_merge u_merge (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .cfg(serialCfg),
    .stat(serialStat),
    .clkRun(serialClkOn),
    .rxFall(rxFall),
    .irqPulseN(uartPulseN),
    .wakeEvt(uartWake)
  );

  assign wrEdge = sfrWr & (sfrAddr == irq_pkg::ADDR_EDGE_SEL);
  assign wrCtrl0 = sfrWr & (sfrAddr == irq_pkg::ADDR_CTRL0);
  assign wrCtrl1 = sfrWr & (sfrAddr == irq_pkg::ADDR_CTRL1);
  assign wrCtrl2 = sfrWr & (sfrAddr == irq_pkg::ADDR_CTRL2);
  assign wrMfi = sfrWr & (sfrAddr == irq_pkg::ADDR_MFI);

  // only the dedicated pin feeds the external source
  assign extEvt = ((edgeSel_q == irq_pkg::EDGE_RISE) & extRise)
                | ((edgeSel_q == irq_pkg::EDGE_FALL) & extFall)
                | ((edgeSel_q == irq_pkg::EDGE_BOTH) & (extRise | extFall));

  // pulses and wakes that land in start-up wait for its end
  assign stRun = (state_q == irq_pkg::ST_RUN);
  assign uartEvt = stRun & (~uartPulseN | uartWake | uartHeld_q);

  assign mfEvt = {periphEvt.timerPCmpA, periphEvt.timerPPeriod,
                  periphEvt.timerCCmpA, periphEvt.timerCPeriod};

  always_comb
  begin
    evt = '0;
    evt[irq_pkg::SRC_EXT] = extEvt;
    evt[irq_pkg::SRC_TB0] = periphEvt.timeBase0;
    evt[irq_pkg::SRC_MF] = |mfEvt;
    evt[irq_pkg::SRC_CONV] = periphEvt.converterDone;
    evt[irq_pkg::SRC_TB1] = periphEvt.timeBase1;
    evt[irq_pkg::SRC_EE] = periphEvt.eepromWriteDone;
    evt[irq_pkg::SRC_SIM] = periphEvt.serialIntfDone;
    evt[irq_pkg::SRC_SPORT] = uartEvt;
  end

  always_comb
  begin
    flagWrMask = '0;
    flagWrVal = '0;
    en_d = en_q;
    flagWrMask[irq_pkg::SRC_EXT] = wrCtrl0;
    flagWrMask[irq_pkg::SRC_TB0] = wrCtrl0;
    flagWrMask[irq_pkg::SRC_MF] = wrCtrl0;
    flagWrMask[irq_pkg::SRC_CONV] = wrCtrl1;
    flagWrMask[irq_pkg::SRC_TB1] = wrCtrl1;
    flagWrMask[irq_pkg::SRC_EE] = wrCtrl1;
    flagWrMask[irq_pkg::SRC_SIM] = wrCtrl1;
    flagWrMask[irq_pkg::SRC_SPORT] = wrCtrl2;
    flagWrVal[irq_pkg::SRC_EXT] = sfrWdata[irq_pkg::C0_EXT_FLAG];
    flagWrVal[irq_pkg::SRC_TB0] = sfrWdata[irq_pkg::C0_TB0_FLAG];
    flagWrVal[irq_pkg::SRC_MF] = sfrWdata[irq_pkg::C0_MF_FLAG];
    flagWrVal[irq_pkg::SRC_CONV] = sfrWdata[irq_pkg::C1_CONV_FLAG];
    flagWrVal[irq_pkg::SRC_TB1] = sfrWdata[irq_pkg::C1_TB1_FLAG];
    flagWrVal[irq_pkg::SRC_EE] = sfrWdata[irq_pkg::C1_EE_FLAG];
    flagWrVal[irq_pkg::SRC_SIM] = sfrWdata[irq_pkg::C1_SIM_FLAG];
    flagWrVal[irq_pkg::SRC_SPORT] = sfrWdata[irq_pkg::C2_SPORT_FLAG];
    if (wrCtrl0)
    begin
      en_d[irq_pkg::SRC_EXT] = sfrWdata[irq_pkg::C0_EXT_EN];
      en_d[irq_pkg::SRC_TB0] = sfrWdata[irq_pkg::C0_TB0_EN];
      en_d[irq_pkg::SRC_MF] = sfrWdata[irq_pkg::C0_MF_EN];
    end
    if (wrCtrl1)
    begin
      en_d[irq_pkg::SRC_CONV] = sfrWdata[irq_pkg::C1_CONV_EN];
      en_d[irq_pkg::SRC_TB1] = sfrWdata[irq_pkg::C1_TB1_EN];
      en_d[irq_pkg::SRC_EE] = sfrWdata[irq_pkg::C1_EE_EN];
      en_d[irq_pkg::SRC_SIM] = sfrWdata[irq_pkg::C1_SIM_EN];
    end
    if (wrCtrl2)
    begin
      en_d[irq_pkg::SRC_SPORT] = sfrWdata[irq_pkg::C2_SPORT_EN];
    end
  end

  // vector entry clears a single-source flag; the serial flag stays for
  // software, as does the shared flag, which any of its sub-events sets
  always_comb
  begin
    ackClr = '0;
    if (vectorTaken && irqSrc_q != irq_pkg::SRC_W'(irq_pkg::SRC_SPORT)
        && irqSrc_q != irq_pkg::SRC_W'(irq_pkg::SRC_MF))
    begin
      ackClr[irqSrc_q] = 1'b1;
    end
  end

  // event set wins over any clear in the same cycle, enable or not
  assign flag_d = evt | (flagWrMask & flagWrVal)
                | (~flagWrMask & flag_q & ~ackClr);
  assign mfFlag_d = mfEvt | (wrMfi ? sfrWdata[irq_pkg::MFI_FLAG_MSB:irq_pkg::MFI_FLAG_LSB]
                                   : mfFlag_q);

  assign hit = flag_q & en_q;

  always_comb
  begin
    pick = '0;
    for (int i = irq_pkg::NUM_SRC - 1; i >= 0; i--)
    begin
      if (hit[i])
      begin
        pick = irq_pkg::SRC_W'(i);
      end
    end
  end

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      irq_pkg::ST_RUN:
        if (!serialClkOn)
          state_d = irq_pkg::ST_OFF;
      irq_pkg::ST_OFF:
        if (serialClkOn)
          state_d = irq_pkg::ST_WARM;
      irq_pkg::ST_WARM:
        if (warmDone)
          state_d = irq_pkg::ST_RUN;
      default:
        state_d = irq_pkg::ST_RUN;
    endcase
  end

  assign warmDone = (warmCnt_q == '0);

  always_comb
  begin
    rdMux = irq_pkg::REG_RESET;
    case (sfrAddr)
      irq_pkg::ADDR_EDGE_SEL:
        rdMux[irq_pkg::EDGE_MSB:irq_pkg::EDGE_LSB] = edgeSel_q;
      irq_pkg::ADDR_CTRL0:
      begin
        rdMux[irq_pkg::C0_GLOBAL_EN] = globalEn_q;
        rdMux[irq_pkg::C0_EXT_EN] = en_q[irq_pkg::SRC_EXT];
        rdMux[irq_pkg::C0_MF_EN] = en_q[irq_pkg::SRC_MF];
        rdMux[irq_pkg::C0_TB0_EN] = en_q[irq_pkg::SRC_TB0];
        rdMux[irq_pkg::C0_EXT_FLAG] = flag_q[irq_pkg::SRC_EXT];
        rdMux[irq_pkg::C0_MF_FLAG] = flag_q[irq_pkg::SRC_MF];
        rdMux[irq_pkg::C0_TB0_FLAG] = flag_q[irq_pkg::SRC_TB0];
      end
      irq_pkg::ADDR_CTRL1:
      begin
        rdMux[irq_pkg::C1_TB1_EN] = en_q[irq_pkg::SRC_TB1];
        rdMux[irq_pkg::C1_CONV_EN] = en_q[irq_pkg::SRC_CONV];
        rdMux[irq_pkg::C1_EE_EN] = en_q[irq_pkg::SRC_EE];
        rdMux[irq_pkg::C1_SIM_EN] = en_q[irq_pkg::SRC_SIM];
        rdMux[irq_pkg::C1_TB1_FLAG] = flag_q[irq_pkg::SRC_TB1];
        rdMux[irq_pkg::C1_CONV_FLAG] = flag_q[irq_pkg::SRC_CONV];
        rdMux[irq_pkg::C1_EE_FLAG] = flag_q[irq_pkg::SRC_EE];
        rdMux[irq_pkg::C1_SIM_FLAG] = flag_q[irq_pkg::SRC_SIM];
      end
      irq_pkg::ADDR_CTRL2:
      begin
        rdMux[irq_pkg::C2_SPORT_EN] = en_q[irq_pkg::SRC_SPORT];
        rdMux[irq_pkg::C2_SPORT_FLAG] = flag_q[irq_pkg::SRC_SPORT];
      end
      irq_pkg::ADDR_MFI:
        rdMux = {mfFlag_q, mfEn_q};
      default:
        rdMux = irq_pkg::REG_RESET;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      edgeSel_q <= irq_pkg::EDGE_OFF;
      en_q <= '0;
      flag_q <= '0;
      mfEn_q <= '0;
      mfFlag_q <= '0;
      sfrRdata_q <= irq_pkg::REG_RESET;
    end
    else
    begin
      if (wrEdge)
        edgeSel_q <= sfrWdata[irq_pkg::EDGE_MSB:irq_pkg::EDGE_LSB];
      if (wrMfi)
        mfEn_q <= sfrWdata[irq_pkg::MFI_EN_MSB:irq_pkg::MFI_EN_LSB];
      en_q <= en_d;
      flag_q <= flag_d;
      mfFlag_q <= mfFlag_d;
      if (sfrRd)
        sfrRdata_q <= rdMux;
    end
  end

  // software write of the global enable wins over the automatic clear
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      globalEn_q <= 1'b0;
    else if (wrCtrl0)
      globalEn_q <= sfrWdata[irq_pkg::C0_GLOBAL_EN];
    else if (vectorTaken)
      globalEn_q <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      irqReq_q <= 1'b0;
      irqSrc_q <= '0;
    end
    else
    begin
      irqReq_q <= globalEn_q & (|hit) & ~stackFull & ~vectorTaken;
      if (!irqReq_q || vectorTaken)
        irqSrc_q <= pick;
    end
  end

  // start-up window after the port clock returns; registers are untouched
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= irq_pkg::ST_RUN;
      warmCnt_q <= '0;
      uartHeld_q <= 1'b0;
      wakeCore_q <= 1'b0;
      rxDiscard_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (state_q == irq_pkg::ST_OFF)
        warmCnt_q <= irq_pkg::STARTUP_W'(STARTUP_COUNT - 1);
      else if (!warmDone)
        warmCnt_q <= warmCnt_q - 1'b1;
      uartHeld_q <= ~stRun & (uartHeld_q | ~uartPulseN | uartWake);
      wakeCore_q <= uartWake;
      rxDiscard_q <= (state_d == irq_pkg::ST_WARM);
    end
  end

  assign sfrRdata = sfrRdata_q;
  assign irqReq = irqReq_q;
  assign irqSrc = irqSrc_q;
  assign wakeCore = wakeCore_q;
  assign rxDiscard = rxDiscard_q;
endmodule // mcu_irq_ctrl

// [dv/core_model.sv]
// processor core model: takes vectors and reports stack state
`timescale 1ns/100ps
module core_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // bench control
  input wire logic ackEn,
  input wire logic [3:0] ackDelay,
  input wire logic fullReq,
  // controller side
  input wire logic irqReq,
  input wire logic [irq_pkg::SRC_W-1:0] irqSrc,
  output logic vectorTaken,
  output logic stackFull,
  output logic [irq_pkg::SRC_W-1:0] takenSrc,
  output logic [7:0] takenCnt
);
  logic [3:0] wait_q;

  assign stackFull = fullReq;

  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      wait_q <= 4'h0;
      vectorTaken <= 1'b0;
      takenSrc <= 3'h0;
      takenCnt <= 8'h00;
    end
    else
    begin
      vectorTaken <= 1'b0;
      wait_q <= 4'h0;
      // never a second take while the first pulse is still seen
      if (irqReq && !vectorTaken && !stackFull && ackEn)
        if (wait_q >= ackDelay)
        begin
          vectorTaken <= 1'b1;
          takenSrc <= irqSrc;
          takenCnt <= takenCnt + 8'h01;
        end
        else
          wait_q <= wait_q + 4'h1;
    end
endmodule // core_model

// [dv/mcu_irq_ctrl_assertions.sv]
// port-level assertions of the interrupt controller
`timescale 1ns/100ps
module mcu_irq_ctrl_assertions #(
  parameter int STARTUP_COUNT = irq_pkg::STARTUP_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // register port
  input wire logic [irq_pkg::SFR_AW-1:0] sfrAddr,
  input wire logic sfrWr,
  input wire logic sfrRd,
  input wire logic [7:0] sfrRdata,
  // power
  input wire logic serialClkOn,
  input wire logic rxDiscard,
  input wire logic wakeCore,
  // core
  input wire logic stackFull,
  input wire logic vectorTaken,
  input wire logic irqReq,
  input wire logic [irq_pkg::SRC_W-1:0] irqSrc
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  logic [15:0] discCnt_q;

  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      discCnt_q <= 16'h0000;
    else
      discCnt_q <= rxDiscard ? discCnt_q + 16'h0001 : 16'h0000;

  a_full_blocks_req: assert property (stackFull |=> !irqReq)
    else $error("request raised while stack full");
  a_rise_needs_room: assert property ($rose(irqReq) |-> !$past(stackFull) && !$past(vectorTaken))
    else $error("request rose without room");
  a_vector_masks_all: assert property (vectorTaken && !sfrWr |=> !irqReq [*2])
    else $error("request soon after vector entry");
  a_src_held: assert property (irqReq && $past(irqReq) |-> $stable(irqSrc))
    else $error("source changed under request");
  a_rdata_held: assert property (!sfrRd |=> $stable(sfrRdata))
    else $error("read data changed without read");
  a_unmapped_zero: assert property (sfrRd && sfrAddr > irq_pkg::ADDR_MFI |=> sfrRdata == 8'h00)
    else $error("unmapped index read nonzero");
  a_edge_sel_bits: assert property (sfrRd && sfrAddr == irq_pkg::ADDR_EDGE_SEL |=> sfrRdata[7:2] == 6'h00)
    else $error("edge select spare bits nonzero");
  a_wake_pulse: assert property (wakeCore |-> !$past(serialClkOn, 2) ##1 !wakeCore)
    else $error("wake pulse outside clock-off or too long");
  a_clk_on_discard: assert property ($rose(serialClkOn) |-> ##[1:3] rxDiscard)
    else $error("no discard window after clock return");
  a_discard_bound: assert property (discCnt_q <= STARTUP_COUNT + 2)
    else $error("discard window too long");
  a_no_sport_warm: assert property (rxDiscard |-> !(irqReq && irqSrc == irq_pkg::SRC_SPORT))
    else $error("serial request during start-up");

  c_sport_vector: cover property (vectorTaken && irqSrc == irq_pkg::SRC_SPORT);
  c_wake: cover property (wakeCore);
  c_discard_end: cover property ($fell(rxDiscard));
endmodule // mcu_irq_ctrl_assertions

bind mcu_irq_ctrl mcu_irq_ctrl_assertions #(.STARTUP_COUNT(STARTUP_COUNT)) chk (
  .clk_sys(clk_sys), .rstn(rstn), .sfrAddr(sfrAddr), .sfrWr(sfrWr), .sfrRd(sfrRd),
  .sfrRdata(sfrRdata), .serialClkOn(serialClkOn), .rxDiscard(rxDiscard), .wakeCore(wakeCore),
  .stackFull(stackFull), .vectorTaken(vectorTaken), .irqReq(irqReq), .irqSrc(irqSrc)
);

// [dv/tb_mcu_irq_ctrl.sv]
// self-checking bench for the interrupt controller
`timescale 1ns/100ps
module tb_mcu_irq_ctrl;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] sfrAddr = 3'h0;
  logic sfrWr = 1'b0;
  logic sfrRd = 1'b0;
  logic [7:0] sfrWdata = 8'h00;
  logic [7:0] sfrRdata, takenCnt, ex8;
  logic extIntPin = 1'b0;
  logic rxPin = 1'b1;
  irq_pkg::periph_evt_t periphEvt = '0;
  irq_pkg::serial_cfg_t serialCfg = '0;
  irq_pkg::serial_cfg_t base = '0;
  irq_pkg::serial_stat_t serialStat = '0;
  logic serialClkOn = 1'b1;
  logic rxDiscard, stackFull, vectorTaken, irqReq, wakeCore, seen;
  logic [2:0] irqSrc, takenSrc;
  logic ackEn = 1'b0;
  logic [3:0] ackDelay = 4'h0;
  logic fullReq = 1'b0;
  logic [31:0] seed = 32'h895B3415;
  logic [23:0] ex;
  int failures = 0;
  int total_checks = 0;
  int expCnt = 0;
  int evIdx[6] = '{8, 3, 6, 7, 5, 4};
  logic [15:0] evEn[6] = '{16'h0800, 16'h0400, 16'h0002, 16'h0001, 16'h0004, 16'h0008};

  mcu_irq_ctrl #(.STARTUP_COUNT(8)) dut (.clk_sys(clk_sys), .rstn(rstn), .sfrAddr(sfrAddr),
    .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
    .extIntPin(extIntPin), .rxPin(rxPin), .periphEvt(periphEvt), .serialCfg(serialCfg),
    .serialStat(serialStat), .serialClkOn(serialClkOn), .rxDiscard(rxDiscard),
    .stackFull(stackFull), .vectorTaken(vectorTaken), .irqReq(irqReq), .irqSrc(irqSrc),
    .wakeCore(wakeCore));
  core_model core (.clk_sys(clk_sys), .rstn(rstn), .ackEn(ackEn), .ackDelay(ackDelay),
    .fullReq(fullReq), .irqReq(irqReq), .irqSrc(irqSrc), .vectorTaken(vectorTaken),
    .stackFull(stackFull), .takenSrc(takenSrc), .takenCnt(takenCnt));

  initial
  begin
    forever #10 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // implemented bits of each index; spare bits and unmapped indices read zero
  function automatic logic [7:0] msk(int a);
    case (a)
      0: return 8'h03;
      1: return 8'h7F;
      2, 4: return 8'hFF;
      3: return 8'h11;
      default: return 8'h00;
    endcase
  endfunction

  // {ctrl0, ctrl1, mfi} after one peripheral event with all enables clear
  function automatic logic [23:0] evtExp(int i);
    case (i)
      8: return 24'h400000;
      7: return 24'h001000;
      6: return 24'h002000;
      5: return 24'h004000;
      4: return 24'h008000;
      default: return {8'h20, 8'h00, 8'(8'h10 << (3 - i))};
    endcase
  endfunction

  task automatic step(int n = 1);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic give_verdict();
    if (failures == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(logic [2:0] a, logic [7:0] d);
    sfrAddr = a;
    sfrWdata = d;
    sfrWr = 1'b1;
    step();
    sfrWr = 1'b0;
    step();
  endtask

  task automatic rdchk(logic [2:0] a, logic [7:0] m, logic [7:0] e);
    sfrAddr = a;
    sfrRd = 1'b1;
    step();
    sfrRd = 1'b0;
    chk8($sformatf("register %0d", a), e & m, sfrRdata & m);
    step();
  endtask

  task automatic clearAll();
    for (int a = 0; a < 5; a++)
      wr(3'(a), 8'h00);
  endtask

  task automatic pulse(logic [8:0] v);
    periphEvt = irq_pkg::periph_evt_t'(v);
    step();
    periphEvt = '0;
    step(3);
  endtask

  task automatic waitTaken(logic [2:0] src);
    expCnt++;
    repeat (60)
      if (takenCnt != expCnt[7:0])
        step();
    chk8("vector count", expCnt[7:0], takenCnt);
    chk8("vector source", {5'h00, src}, {5'h00, takenSrc});
    step();
  endtask

  task automatic serialEvt(logic [6:0] s);
    serialStat = irq_pkg::serial_stat_t'(s);
    step(4);
    serialStat = '0;
    step(2);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    give_verdict();
  end

  initial
  begin
    base.serialPortEnable = 1'b1;
    base.receiverEnable = 1'b1;
    base.parityEnable = 1'b0;
    serialCfg = base;
    repeat (10) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    for (int a = 0; a < 8; a++)
      rdchk(3'(a), 8'hFF, 8'h00);
    for (int a = 0; a < 8; a++)
    begin
      ex8 = 8'(rnd());
      wr(3'(a), ex8);
      rdchk(3'(a), 8'hFF, ex8 & msk(a));
    end
    clearAll();
    ackEn = 1'b1;
    for (int i = 0; i < 9; i++)
    begin
      clearAll();
      pulse(9'h001 << i);
      ex = evtExp(i);
      rdchk(irq_pkg::ADDR_CTRL0, 8'hFF, ex[23:16]);
      rdchk(irq_pkg::ADDR_CTRL1, 8'hFF, ex[15:8]);
      rdchk(irq_pkg::ADDR_MFI, 8'hFF, ex[7:0]);
    end
    for (int k = 0; k < 6; k++)
    begin
      clearAll();
      wr(irq_pkg::ADDR_CTRL1, evEn[k][7:0]);
      wr(irq_pkg::ADDR_MFI, 8'h0F);
      fullReq = 1'b1;
      wr(irq_pkg::ADDR_CTRL0, evEn[k][15:8] | 8'h01);
      pulse(9'h001 << evIdx[k]);
      step(3);
      chk8("request", 8'h00, {7'h00, irqReq});
      ackDelay = 4'(rnd() & 32'h7);
      fullReq = 1'b0;
      waitTaken(3'(k + 1));
      rdchk(irq_pkg::ADDR_CTRL0, 8'hFF, evEn[k][15:8] | (k == 1 ? 8'h20 : 8'h00));
      rdchk(irq_pkg::ADDR_CTRL1, 8'hFF, evEn[k][7:0]);
    end
    // two pending sources: the lower index goes first, the other after re-enable
    clearAll();
    wr(irq_pkg::ADDR_CTRL1, 8'h03);
    pulse(9'h0C0);
    wr(irq_pkg::ADDR_CTRL0, 8'h01);
    waitTaken(3'h3);
    wr(irq_pkg::ADDR_CTRL0, 8'h01);
    waitTaken(3'h4);
    for (int m = 0; m < 4; m++)
      for (int e = 0; e < 2; e++)
      begin
        wr(irq_pkg::ADDR_CTRL0, 8'h00);
        wr(irq_pkg::ADDR_EDGE_SEL, 8'(m));
        extIntPin = (e == 0);
        step(6);
        rdchk(irq_pkg::ADDR_CTRL0, 8'h10, ((e == 0) ? m[0] : m[1]) ? 8'h10 : 8'h00);
      end
    wr(irq_pkg::ADDR_EDGE_SEL, 8'h01);
    wr(irq_pkg::ADDR_CTRL0, 8'h03);
    extIntPin = 1'b1;
    waitTaken(3'h0);
    rdchk(irq_pkg::ADDR_CTRL0, 8'hFF, 8'h02);
    for (int c = 0; c < 4; c++)
      for (int en = 0; en < 2; en++)
      begin
        wr(irq_pkg::ADDR_CTRL2, 8'h00);
        serialCfg = base;
        serialCfg.txEmptyIrqEnable = c != 0 || en;
        serialCfg.txIdleIrqEnable = c != 1 || en;
        serialCfg.rxIrqEnable = c < 2 || en;
        serialEvt(7'(7'h40 >> c));
        rdchk(irq_pkg::ADDR_CTRL2, 8'h10, en ? 8'h10 : 8'h00);
      end
    for (int k = 0; k < 16; k++)
    begin
      wr(irq_pkg::ADDR_CTRL2, 8'h00);
      serialCfg = base;
      serialCfg.rxIrqEnable = 1'b1;
      serialCfg.addrDetectMode = !k[3];
      serialCfg.nineBitWordSelect = k[0];
      // top bit of the selected width carries k[1], the other one its inverse
      serialEvt({5'h00, k[0] ? k[1] : !k[1], k[0] ? !k[1] : k[1]} |
        (k[2] ? 7'h04 : 7'h10));
      rdchk(irq_pkg::ADDR_CTRL2, 8'h10, (k[3] ? !k[2] : k[1]) ? 8'h10 : 8'h00);
    end
    clearAll();
    serialCfg = base;
    serialCfg.txEmptyIrqEnable = 1'b1;
    serialEvt(7'h40);
    wr(irq_pkg::ADDR_CTRL0, 8'h01);
    step(4);
    chk8("masked request", 8'h00, {7'h00, irqReq});
    wr(irq_pkg::ADDR_CTRL2, 8'h11);
    waitTaken(3'h7);
    rdchk(irq_pkg::ADDR_CTRL2, 8'hFF, 8'h11);
    for (int wk = 0; wk < 3; wk++)
    begin
      clearAll();
      serialCfg = base;
      serialCfg.rxIrqEnable = 1'b1;
      serialCfg.wakeEnable = wk != 0;
      wr(irq_pkg::ADDR_CTRL2, (wk == 1) ? 8'h01 : 8'h00);
      wr(irq_pkg::ADDR_CTRL0, 8'h01);
      serialClkOn = 1'b0;
      step(3);
      rxPin = 1'b0;
      seen = 1'b0;
      repeat (10)
      begin
        step();
        seen |= wakeCore;
      end
      chk8("wake", {7'h00, wk != 0}, {7'h00, seen});
      rxPin = 1'b1;
      serialClkOn = 1'b1;
      step(3);
      chk8("discard", 8'h01, {7'h00, rxDiscard});
      rdchk(irq_pkg::ADDR_CTRL2, 8'h10, 8'h00);
      repeat (40)
        if (rxDiscard)
          step();
      step(2);
      rdchk(irq_pkg::ADDR_CTRL2, 8'h10, (wk != 0) ? 8'h10 : 8'h00);
      if (wk == 1)
        waitTaken(3'h7);
      chk8("wake request", 8'h00, {7'h00, irqReq});
    end
    give_verdict();
  end
endmodule // tb_mcu_irq_ctrl
